/* hw/ttpu_top.sv */
// Three timers: two duty-cycle timers with pins, one prescale timer
//
// Overview of operation
// - Timers advance at one quarter clock rate
// - Power save slows the count clock
// - Output high to first limit, low to second
// - Timers a,b have first and second limits
// - Prescale timer has one limit, no pins
// - Prescale timer output may feed a or b
// - Counters and limits are sixteen bits
// - Each timer has its own control register
// - Full count raises interrupt when enabled
// - Limit reached flag set, pollable by software
// - Current count readable without disturbing counting
`timescale 1ns/1ps
`default_nettype none
module ttpu_top (
   input  wire logic               clk,
   input  wire logic               srst,
   input  wire logic               power_save,      // Processor in power save
   input  wire logic [3:0]         save_div,        // Reduced clock divide ratio minus one
   input  wire logic [2:0]         ctrl_we,         // Control write strobes a, b, prescale
   input  wire ttpu_pkg::ttpu_ctrl_t ctrl_wdata,    // Control write data
   input  wire logic [2:0]         flag_clr,        // Clear limit reached flags
   input  wire ttpu_pkg::ttpu_cnt_t first_limit_a,  // Timer a first limit
   input  wire ttpu_pkg::ttpu_cnt_t second_limit_a, // Timer a second limit
   input  wire ttpu_pkg::ttpu_cnt_t first_limit_b,  // Timer b first limit
   input  wire ttpu_pkg::ttpu_cnt_t second_limit_b, // Timer b second limit
   input  wire ttpu_pkg::ttpu_cnt_t first_limit_p,  // Prescale timer limit
   output logic [2:0]              limit_reached_flag, // Sticky per-timer flags
   output logic [2:0]              irq,             // One-cycle interrupt requests
   output logic [1:0]              timer_out,       // Pins of timers a and b
   output ttpu_pkg::ttpu_cnt_t     count_a,         // Current counts, read freely
   output ttpu_pkg::ttpu_cnt_t     count_b,
   output ttpu_pkg::ttpu_cnt_t     count_p,
   output ttpu_pkg::ttpu_ctrl_t    timer_a_control, // Control readback
   output ttpu_pkg::ttpu_ctrl_t    timer_b_control,
   output ttpu_pkg::ttpu_ctrl_t    prescale_control
);
   import ttpu_pkg::*;

   // ************************************************************
   // Count clock enable
   // ************************************************************
   logic [2:0] qdiv;            // Quarter divider phase
   logic [3:0] sdiv;            // Power-save slow-down divider
   logic       tick;            // One-cycle count enable
   logic [2:0] next_qdiv;
   logic [3:0] next_sdiv;
   logic       next_tick;

   // Quarter rate; in power save only every save_div+1 quarter ticks pass
   always_comb begin
      next_qdiv = (qdiv == DIV_LAST) ? 3'h0 : qdiv + 3'h1;
      next_sdiv = sdiv;
      next_tick = 1'b0;
      if (qdiv == DIV_LAST) begin
         if (!power_save || sdiv >= save_div) begin
            next_sdiv = SAVE_DIV_RST;
            next_tick = 1'b1;
         end else begin
            next_sdiv = sdiv + 4'h1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         qdiv <= 3'h0;
         sdiv <= SAVE_DIV_RST;
         tick <= 1'b0;
      end else begin
         qdiv <= next_qdiv;
         sdiv <= next_sdiv;
         tick <= next_tick;
      end
   end

   // ************************************************************
   // Timer state
   // ************************************************************
   ttpu_ctrl_t  ctrl  [3];       // Control registers a, b, prescale
   ttpu_cnt_t   cnt   [3];       // Counters
   ttpu_phase_e ph    [3];       // Which limit is being counted to
   logic [2:0]  done;            // Stopped after one shot
   logic [2:0]  hit;             // Full count this cycle
   logic [2:0]  flag;
   logic [2:0]  irq_r;
   logic [1:0]  pin;
   ttpu_ctrl_t  next_ctrl [3];
   ttpu_cnt_t   next_cnt  [3];
   ttpu_phase_e next_ph   [3];
   logic [2:0]  next_done;
   logic [2:0]  next_flag;
   logic [2:0]  next_irq;
   logic [1:0]  next_pin;
   ttpu_cnt_t   lim_a [3];       // First limit per timer
   ttpu_cnt_t   lim_b [3];       // Second limit per timer
   logic [2:0]  step;            // Count enable per timer

   assign lim_a[0] = first_limit_a;
   assign lim_b[0] = second_limit_a;
   assign lim_a[1] = first_limit_b;
   assign lim_b[1] = second_limit_b;
   assign lim_a[2] = first_limit_p;
   assign lim_b[2] = first_limit_p;

   // Prescale timer hits feed a or b when selected; its one limit only
   assign step[2] = tick;
   assign step[0] = ctrl[0][PRE_BIT] ? hit[2] : tick;
   assign step[1] = ctrl[1][PRE_BIT] ? hit[2] : tick;

   // A limit of zero counts as full range
   function automatic logic at_limit(input ttpu_cnt_t c, input ttpu_cnt_t l);
      at_limit = (c == l - 16'h0001);
   endfunction

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_hit
         // Full count: end of the last limit of the period
         assign hit[gi] = ctrl[gi][EN_BIT] && !done[gi] && step[gi]
            && at_limit(cnt[gi], (ph[gi] == TTPU_PH_A) ? lim_a[gi] : lim_b[gi])
            && (gi == 2 || !ctrl[gi][ALT_BIT] || ph[gi] == TTPU_PH_B);
      end
   endgenerate

   // Counting, phase, flags and interrupts
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         next_ctrl[i] = ctrl[i];
         next_cnt[i]  = cnt[i];
         next_ph[i]   = ph[i];
         next_done[i] = done[i];
         next_flag[i] = flag[i];
         next_irq[i]  = 1'b0;
         if (ctrl_we[i]) begin
            next_ctrl[i] = ctrl_wdata;
            next_done[i] = 1'b0;
            next_ph[i]   = TTPU_PH_A;
            next_cnt[i]  = CNT_RST;
         end else if (ctrl[i][EN_BIT] && !done[i] && step[i]) begin
            if (at_limit(cnt[i], (ph[i] == TTPU_PH_A) ? lim_a[i] : lim_b[i])) begin
               next_cnt[i] = CNT_RST;
               if (i != 2 && ctrl[i][ALT_BIT] && ph[i] == TTPU_PH_A) begin
                  next_ph[i] = TTPU_PH_B;
               end else begin
                  next_ph[i]   = TTPU_PH_A;
                  next_done[i] = !ctrl[i][CONT_BIT];
               end
            end else begin
               next_cnt[i] = cnt[i] + 16'h0001;
            end
         end
         if (flag_clr[i]) begin
            next_flag[i] = 1'b0;
         end
         if (hit[i]) begin
            next_flag[i] = 1'b1;
            next_irq[i]  = ctrl[i][INT_BIT];
         end
      end
      // Pin high in first phase, low in second; single-limit mode toggles
      for (int j = 0; j < 2; j++) begin
         next_pin[j] = pin[j];
         if (!ctrl[j][EN_BIT]) begin
            next_pin[j] = 1'b0;
         end else if (ctrl[j][ALT_BIT]) begin
            next_pin[j] = (next_ph[j] == TTPU_PH_A);
         end else if (hit[j]) begin
            next_pin[j] = !pin[j];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         for (int i = 0; i < 3; i++) begin
            ctrl[i] <= CTRL_RST;
            cnt[i]  <= CNT_RST;
            ph[i]   <= TTPU_PH_A;
         end
         done  <= 3'h0;
         flag  <= 3'h0;
         irq_r <= 3'h0;
         pin   <= 2'h0;
      end else begin
         for (int i = 0; i < 3; i++) begin
            ctrl[i] <= next_ctrl[i];
            cnt[i]  <= next_cnt[i];
            ph[i]   <= next_ph[i];
         end
         done  <= next_done;
         flag  <= next_flag;
         irq_r <= next_irq;
         pin   <= next_pin;
      end
   end

   // ************************************************************
   // Outputs, all from flip-flops
   // ************************************************************
   always_comb begin
      limit_reached_flag = flag;
      irq                = irq_r;
      timer_out          = pin;
      count_a            = cnt[0];
      count_b            = cnt[1];
      count_p            = cnt[2];
      timer_a_control    = ctrl[0];
      timer_b_control    = ctrl[1];
      prescale_control   = ctrl[2];
      timer_a_control[FLAG_BIT]  = flag[0];
      timer_b_control[FLAG_BIT]  = flag[1];
      prescale_control[FLAG_BIT] = flag[2];
   end

   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   // The tick itself is high in the antecedent cycle, so the quiet run starts one cycle later
   tick_spacing_a: assert property (tick && !power_save |=> !tick [*3])
      else $error("count tick closer than four cycles");
   // Power save must still be on when the next quarter wrap decides on a tick
   save_slow_a: assert property ((tick && power_save) ##3 (power_save && save_div != 4'h0)
         |=> !tick)
      else $error("power save did not slow count tick");
   pin_phase_a: assert property (ctrl[0][EN_BIT] && ctrl[0][ALT_BIT] && !ctrl_we[0]
         |=> timer_out[0] == (ph[0] == TTPU_PH_A))
      else $error("timer a pin not tied to phase");
   flag_set_a: assert property (hit[0] |=> limit_reached_flag[0])
      else $error("limit flag not set on full count");
   irq_en_a: assert property (hit[1] |=> irq[1] == $past(ctrl[1][INT_BIT]))
      else $error("interrupt not matching enable");
   wrap_a: assert property (hit[2] && ctrl[2][CONT_BIT] && !ctrl_we[2]
         |=> count_p == 16'h0000 && !done[2])
      else $error("continuous timer failed to restart");
   count_hold_a: assert property (!step[0] && !ctrl_we[0] |=> $stable(count_a))
      else $error("count moved without a step");
   prescale_a: assert property (ctrl[0][PRE_BIT] && !hit[2] |-> !step[0])
      else $error("timer a stepped without prescale hit");
   ctrl_load_a: assert property (ctrl_we[2] |=> prescale_control[EN_BIT] == $past(ctrl_wdata[EN_BIT]))
      else $error("control write not taken");

   cover_pwm: cover property (ph[0] == TTPU_PH_A ##1 ph[0] == TTPU_PH_B);
   cover_irq: cover property (irq[0]);
   cover_pre: cover property (ctrl[1][PRE_BIT] && step[1]);
   cover_save: cover property (power_save && tick);
endmodule
`default_nettype wire

/* shared/ttpu_pkg.sv */
// Package of constants and types for the triple timer PWM unit
`default_nettype none
package ttpu_pkg;
   localparam int unsigned CNT_W         = 16;            // Counter and limit width
   localparam int unsigned CTRL_W        = 16;            // Control register width
   localparam int unsigned QUARTER_DIV   = 4;             // Count clock is clock over four
   localparam logic [2:0]  DIV_LAST      = 3'h3;          // Last phase of quarter divider
   localparam logic [3:0]  SAVE_DIV_RST  = 4'h0;          // Power-save divider reset value
   localparam logic [CNT_W-1:0] CNT_RST  = 16'h0000;      // Counter value after reset
   localparam logic [CTRL_W-1:0] CTRL_RST = 16'h0000;     // Control value after reset
   // Control field positions
   localparam int unsigned EN_BIT        = 15;            // Timer runs
   localparam int unsigned INT_BIT       = 13;            // Interrupt enable
   localparam int unsigned FLAG_BIT      = 5;             // Limit reached flag (read)
   localparam int unsigned ALT_BIT       = 1;             // Use both limits (duty cycle)
   localparam int unsigned CONT_BIT      = 0;             // Continuous operation
   localparam int unsigned PRE_BIT       = 3;             // Count prescale timer output
   typedef logic [CNT_W-1:0] ttpu_cnt_t;
   typedef logic [CTRL_W-1:0] ttpu_ctrl_t;
   // Phase of a duty-cycle timer
   typedef enum logic [1:0] {
      TTPU_PH_A = 2'b01,
      TTPU_PH_B = 2'b10
   } ttpu_phase_e;
endpackage
`default_nettype wire

/* bench/tb.sv */
// Self-checking bench for the triple timer PWM unit
`timescale 1ns/1ps
`default_nettype none
module tb;
   import ttpu_pkg::*;
   // ***************
   // Signals
   // ***************
   logic       clk = 1'b0;
   logic       srst = 1'b1;
   logic       power_save = 1'b0;
   logic [3:0] save_div = 4'h0;
   logic [2:0] ctrl_we = 3'h0;
   logic [2:0] flag_clr = 3'h0;
   logic [2:0] flag, irq;
   logic [1:0] tout;
   ttpu_ctrl_t ctrl_wdata = 16'h0000;
   ttpu_cnt_t  lim [5] = '{default: 16'h0004}; // a first, a second, b first, b second, p
   ttpu_cnt_t  cnt [3];
   ttpu_ctrl_t ctl [3];
   int         bad_count = 0, num_checks = 0, seed = 32'h0edc, d, lm, n;
   int         mc[3], mph[3], mout[3], mst[3], mfl[3], mirq[3];
   ttpu_ctrl_t mctl[3];
   bit         tk, nt, chk_on = 1'b0;
   always #50 clk = ~clk;
   ttpu_top u_ttpu_top (.clk(clk), .srst(srst), .power_save(power_save), .save_div(save_div),
      .ctrl_we(ctrl_we), .ctrl_wdata(ctrl_wdata), .flag_clr(flag_clr),
      .first_limit_a(lim[0]), .second_limit_a(lim[1]), .first_limit_b(lim[2]),
      .second_limit_b(lim[3]), .first_limit_p(lim[4]), .limit_reached_flag(flag), .irq(irq),
      .timer_out(tout), .count_a(cnt[0]), .count_b(cnt[1]), .count_p(cnt[2]),
      .timer_a_control(ctl[0]), .timer_b_control(ctl[1]), .prescale_control(ctl[2]));
   // ***************
   // Reference model
   // ***************
   // Steps on the same edge as the design; the free-running quarter divider is
   // only modelled at full speed, so checks stop once power save is entered
   always @(posedge clk) begin
      if (srst) begin
         d = 0;
         nt = 1'b0;
         for (int i = 0; i < 3; i++) begin
            mc[i] = 0; mph[i] = 0; mout[i] = 0; mst[i] = 0; mfl[i] = 0; mirq[i] = 0;
            mctl[i] = 16'h0000;
         end
      end else begin
         // The tick is registered, so a step lags the divider wrap by one edge
         tk = nt;
         nt = (d == QUARTER_DIV - 1);
         d = (d + 1) % QUARTER_DIV;
         for (int i = 0; i < 3; i++) begin
            mirq[i] = 0;
            lm = (i == 2) ? lim[4] : lim[2*i + mph[i]];
            if (lm == 0) lm = 65536;
            if (flag_clr[i]) mfl[i] = 0;
            if (ctrl_we[i]) begin
               mctl[i] = ctrl_wdata & 16'hFFDF; mc[i] = 0; mph[i] = 0; mst[i] = 0; mout[i] = -1;
            end else if (mctl[i][EN_BIT] && !mst[i] && tk && !mctl[i][PRE_BIT]) begin
               if (mc[i] != lm - 1) mc[i]++;
               else begin
                  mc[i] = 0;
                  if (mctl[i][ALT_BIT] && mph[i] == 0) begin
                     mph[i] = 1; mout[i] = 0;
                  end else begin
                     if (mctl[i][ALT_BIT]) mout[i] = 1;
                     else if (mout[i] >= 0) mout[i] = 1 - mout[i];
                     mph[i] = 0; mfl[i] = 1; mirq[i] = mctl[i][INT_BIT];
                     if (!mctl[i][CONT_BIT]) mst[i] = 1;
                  end
               end
            end
         end
      end
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Outputs are compared mid-cycle, after the edge's updates have landed
   always @(negedge clk) if (chk_on) for (int i = 0; i < 3; i++) begin
      check(cnt[i], mc[i][15:0]);
      check(flag[i], mfl[i][15:0]);
      check(irq[i], mirq[i][15:0]);
      check(ctl[i], mctl[i] | 16'(mfl[i] << FLAG_BIT));
      if (i < 2 && mout[i] >= 0) check(tout[i], mout[i][15:0]);
   end
   // ***************
   // Stimulus tasks
   // ***************
   task automatic run(input int k);
      repeat (k) @(posedge clk);
   endtask
   task automatic wr(input logic [2:0] w, input ttpu_ctrl_t v);
      @(posedge clk); ctrl_we <= w; ctrl_wdata <= v;
      @(posedge clk); ctrl_we <= 3'h0;
   endtask
   function automatic ttpu_cnt_t rl(input int m);
      rl = ttpu_cnt_t'(($random(seed) & 32'h7FFF) % m + 1);
   endfunction
   // Cycles between two steps of the prescale count, bounded
   task automatic gap(output int k);
      ttpu_cnt_t v;
      k = 0; v = cnt[2];
      while (cnt[2] === v && k < 300) begin @(negedge clk); k++; end
      if (k == 300) begin bad_count++; report_and_stop; end
   endtask
   task automatic report_and_stop;
      $display("checks=%0d mismatches=%0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // ***************
   // Main sequence
   // ***************
   initial begin
      run(16); srst <= 1'b0; chk_on = 1'b1; run(4);
      $display("test reset done");
      lim[0] <= rl(8); lim[1] <= rl(8); lim[4] <= rl(8);
      wr(3'h1, 16'hA003);
      wr(3'h4, 16'h8001);
      run(300); flag_clr <= 3'h7; @(posedge clk); flag_clr <= 3'h0; run(60);
      $display("test duty cycle done");
      lim[2] <= rl(16);
      wr(3'h2, 16'hA000);
      n = 0;
      while (flag[1] !== 1'b1 && n < 200) begin run(1); n++; end
      if (n == 200) begin bad_count++; report_and_stop; end
      run(100);
      $display("test one shot done");
      chk_on = 1'b0; save_div <= 4'h2; power_save <= 1'b1; lim[4] <= 16'h0000;
      wr(3'h4, 16'h8001);
      @(negedge clk); gap(n); gap(n);
      check(n[15:0], 16'(QUARTER_DIV * 3));
      $display("test power save done");
      @(posedge clk);
      power_save <= 1'b0; lim[4] <= 16'h0002; lim[0] <= 16'h0100;
      wr(3'h4, 16'h8001);
      wr(3'h1, 16'h8009);
      run(160);
      @(negedge clk);
      check(16'(cnt[0] >= 16'h0013 && cnt[0] <= 16'h0015), 16'h0001);
      $display("test prescale source done");
      report_and_stop;
   end
endmodule
`default_nettype wire
